// ==== hw/oag_alu.sv ====
// Accumulator/index arithmetic and logic for the register/memory group
`timescale 1ns/100ps
`default_nettype none
module oag_alu (
    input wire logic [3:0] op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] idx_i,
    input wire logic [7:0] opnd_i,
    input wire logic carry_i,
    output logic [7:0] res_o,
    output logic wr_acc_o,
    output logic wr_idx_o,
    output logic upd_c_o,
    output logic upd_h_o,
    output logic c_o,
    output logic h_o
);
    import oag_pkg::*;

    logic [8:0] sum9;
    logic [4:0] half5;

    // Result, destination and carry selection per operation
    always_comb begin
        sum9 = 9'h000;
        half5 = 5'h00;
        res_o = 8'h00;
        wr_acc_o = 1'b0;
        wr_idx_o = 1'b0;
        upd_c_o = 1'b0;
        upd_h_o = 1'b0;
        c_o = 1'b0;
        h_o = 1'b0;
        case (op_i)
            OAG_SUB, OAG_COMPARE_ACCUMULATOR_OP, OAG_SUBTRACT_WITH_BORROW_OP: begin
                sum9 = {1'b0, acc_i} - {1'b0, opnd_i}
                    - {8'h00, carry_i & (op_i == OAG_SUBTRACT_WITH_BORROW_OP)}; // [RULE15]
                res_o = sum9[7:0];
                wr_acc_o = (op_i != OAG_COMPARE_ACCUMULATOR_OP); // Compare only flags
                upd_c_o = 1'b1;
                c_o = sum9[8];
            end
            OAG_COMPARE_INDEX_OP: begin
                sum9 = {1'b0, idx_i} - {1'b0, opnd_i};
                res_o = sum9[7:0];
                upd_c_o = 1'b1;
                c_o = sum9[8];
            end
            OAG_AND, OAG_BIT_TEST: begin
                res_o = acc_i & opnd_i;
                wr_acc_o = (op_i == OAG_AND); // Logical compare keeps A [RULE14]
            end
            OAG_LOAD_ACCUMULATOR_OP: begin
                res_o = opnd_i;
                wr_acc_o = 1'b1;
            end
            OAG_STORE_ACC: begin
                res_o = acc_i;
            end
            OAG_EXCLUSIVE_OR_OP: begin
                res_o = acc_i ^ opnd_i; // [RULE17]
                wr_acc_o = 1'b1;
            end
            OAG_ADD_WITH_CARRY, OAG_ADD: begin
                sum9 = {1'b0, acc_i} + {1'b0, opnd_i}
                    + {8'h00, carry_i & (op_i == OAG_ADD_WITH_CARRY)}; // [RULE16]
                half5 = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]}
                    + {4'h0, carry_i & (op_i == OAG_ADD_WITH_CARRY)};
                res_o = sum9[7:0];
                wr_acc_o = 1'b1;
                upd_c_o = 1'b1;
                upd_h_o = 1'b1;
                c_o = sum9[8];
                h_o = half5[4];
            end
            OAG_OR: begin
                res_o = acc_i | opnd_i;
                wr_acc_o = 1'b1;
            end
            OAG_LOAD_INDEX: begin
                res_o = opnd_i;
                wr_idx_o = 1'b1;
            end
            OAG_STORE_INDEX: begin
                res_o = idx_i;
            end
            default: begin
                res_o = acc_i;
            end
        endcase
    end

endmodule // oag_alu
`default_nettype wire

// ==== hw/oag_core.sv ====
// Operand address generator, opcode decoder and sequencer of the CPU core
//
// Summary of operation
// RULE1: Indexed no-offset: address is zero-extended X, one-byte instruction.
// RULE2: Short offset: unsigned byte after opcode added to X.
// RULE3: Short offset base high byte is zero; highest address is 1FE.
// RULE4: Long offset: X added to 16-bit value from two bytes, three bytes.
// RULE5: Long offset: first byte is base high half, second byte low half.
// RULE6: Offset indexing never changes X; only the address uses the sum.
// RULE7: Branch target is next-instruction PC plus signed displacement byte.
// RULE8: False condition continues at the instruction after the branch.
// RULE9: Ordinary relative branches are two bytes: opcode and displacement.
// RULE10: Opcode 27 reads displacement, branches only when zero flag set.
// RULE11: Bit-test branches use a direct-page operand and relative displacement.
// RULE12: Compare A decodes A1/B1/C1/F1/E1/D1; compare X uses A3 family.
// RULE13: Read ops take 2 imm, 3 dir, 4 ext, 3 ix, 4 ix1, 5 ix2 cycles.
// RULE14: Opcode A5 ANDs A with operand, sets flags, keeps A.
// RULE15: A2 family subtracts operand and borrow from A.
// RULE16: A9 family adds operand and carry to A.
// RULE17: A8 family replaces A with A exclusive-or operand.
// RULE18: Upper nibble selects mode A,B,C,D,E,F; lower nibble selects operation.
// RULE19: Direct mode address high byte is zero, low byte follows opcode.
`timescale 1ns/100ps
`default_nettype none
module oag_core #(
    parameter logic [15:0] RESET_PC = oag_pkg::OAG_RESET_PC
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic irq_pin_i,
    output logic [15:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [7:0] mem_wdata_o,
    output logic [15:0] pc_o,
    output logic [7:0] acc_o,
    output logic [7:0] idx_o,
    output logic [4:0] ccr_o,
    output logic insn_done_o,
    output logic illegal_op_o
);
    import oag_pkg::*;

    typedef struct packed {
        logic [2:0] cyc;
        logic [7:0] op;
        logic [15:0] pc;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] acc;
        logic [7:0] idx;
        logic [4:0] ccr;
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic done;
        logic illegal;
        logic [1:0] irq_sync;
    } oag_state_s;

    localparam oag_state_s OAG_STATE_RESET = '{
        cyc: OAG_CYC_FIRST, op: 8'h00, pc: RESET_PC, b1: 8'h00, b2: 8'h00,
        acc: 8'h00, idx: 8'h00, ccr: OAG_CCR_RESET, addr: RESET_PC,
        rd: 1'b1, wr: 1'b0, wdata: 8'h00, done: 1'b0, illegal: 1'b0,
        irq_sync: 2'h0};

    oag_state_s cur_ff;
    oag_state_s nxt_cur;

    logic [7:0] op_cur;
    oag_class_e cls;
    oag_mode_e mode;
    logic [1:0] len;
    logic [2:0] fin_cyc;
    logic [2:0] ea_cyc;
    logic is_store;
    logic [15:0] ea;
    logic [2:0] read_cyc;
    logic [1:0] mode_len;
    logic [7:0] rel_byte;
    logic [15:0] pc_seq;
    logic [15:0] pc_target;
    logic cond_true;
    logic tested_bit;
    logic [7:0] alu_res;
    logic alu_wr_acc;
    logic alu_wr_idx;
    logic alu_upd_c;
    logic alu_upd_h;
    logic alu_c;
    logic alu_h;

    // Opcode is live on the bus in cycle 1 and held afterwards
    assign op_cur = (cur_ff.cyc == OAG_CYC_FIRST) ? mem_rdata_i : cur_ff.op;

    // Cycle count and length of each register/memory addressing mode
    always_comb begin
        mode = oag_mode_e'(3'(op_cur[7:4] - OAG_HI_IMM)); // [RULE18]
        case (mode)
            OAG_MODE_IMM: begin
                read_cyc = OAG_CYC_IMM; // [RULE13]
                mode_len = OAG_LEN_2;
            end
            OAG_MODE_DIR: begin
                read_cyc = OAG_CYC_DIR; // [RULE13]
                mode_len = OAG_LEN_2;
            end
            OAG_MODE_EXT: begin
                read_cyc = OAG_CYC_EXT; // [RULE13]
                mode_len = OAG_LEN_3;
            end
            OAG_MODE_IX2: begin
                read_cyc = OAG_CYC_IX2; // [RULE13]
                mode_len = OAG_LEN_3; // [RULE4]
            end
            OAG_MODE_IX1: begin
                read_cyc = OAG_CYC_IX1; // [RULE13]
                mode_len = OAG_LEN_2;
            end
            OAG_MODE_IX: begin
                read_cyc = OAG_CYC_IX; // [RULE13]
                mode_len = OAG_LEN_1; // [RULE1]
            end
            default: begin
                read_cyc = OAG_CYC_NOP;
                mode_len = OAG_LEN_1;
            end
        endcase
    end

    // Instruction class, length and the cycles of address and completion
    always_comb begin
        cls = OAG_CLS_NOP;
        len = OAG_LEN_1;
        fin_cyc = OAG_CYC_NOP;
        ea_cyc = 3'h0;
        is_store = 1'b0;
        if (op_cur[7:4] == OAG_HI_BTB) begin
            cls = OAG_CLS_BTB; // [RULE11]
            len = OAG_LEN_3;
            fin_cyc = OAG_CYC_BTB;
            ea_cyc = OAG_CYC_BTB - 3'h1;
        end else if (op_cur[7:4] == OAG_HI_REL) begin
            cls = OAG_CLS_REL;
            len = OAG_LEN_2; // [RULE9]
            fin_cyc = OAG_CYC_REL;
        end else if (op_cur[7:4] >= OAG_HI_IMM
            && op_cur[3:0] != OAG_JUMP && op_cur[3:0] != OAG_JUMP_SUB
            && !(mode == OAG_MODE_IMM && (op_cur[3:0] == OAG_STORE_ACC
            || op_cur[3:0] == OAG_STORE_INDEX))) begin
            // Lower nibble picks the operation in every mode [RULE12] [RULE18]
            cls = OAG_CLS_ALU;
            len = mode_len;
            is_store = (op_cur[3:0] == OAG_STORE_ACC) || (op_cur[3:0] == OAG_STORE_INDEX);
            fin_cyc = read_cyc + (is_store ? OAG_CYC_STORE_EXTRA : 3'h0);
            ea_cyc = read_cyc - 3'h1;
        end
    end

    // Effective address, formed in the cycle before the data is needed
    always_comb begin
        if (cls == OAG_CLS_BTB) begin
            ea = {8'h00, cur_ff.b1}; // Direct-page byte under test [RULE11]
        end else begin
            case (mode)
                OAG_MODE_IMM: ea = cur_ff.pc + 16'h0001;
                OAG_MODE_DIR: ea = {8'h00, mem_rdata_i}; // [RULE19]
                OAG_MODE_EXT: ea = {cur_ff.b1, mem_rdata_i};
                OAG_MODE_IX2: ea = {cur_ff.b1, cur_ff.b2} + {8'h00, cur_ff.idx}; // [RULE4] [RULE5]
                OAG_MODE_IX1: ea = {8'h00, cur_ff.b1} + {8'h00, cur_ff.idx}; // [RULE2] [RULE3]
                OAG_MODE_IX: ea = {8'h00, cur_ff.idx}; // [RULE1]
                default: ea = cur_ff.pc;
            endcase
        end
    end

    // Branch condition of the relative group
    always_comb begin
        case (cur_ff.op[3:0])
            4'h0: cond_true = 1'b1;
            4'h1: cond_true = 1'b0;
            4'h2: cond_true = !(cur_ff.ccr[OAG_CCR_C] | cur_ff.ccr[OAG_CCR_Z]);
            4'h3: cond_true = cur_ff.ccr[OAG_CCR_C] | cur_ff.ccr[OAG_CCR_Z];
            4'h4: cond_true = !cur_ff.ccr[OAG_CCR_C];
            4'h5: cond_true = cur_ff.ccr[OAG_CCR_C];
            4'h6: cond_true = !cur_ff.ccr[OAG_CCR_Z];
            4'h7: cond_true = cur_ff.ccr[OAG_CCR_Z]; // Opcode 27 [RULE10]
            4'h8: cond_true = !cur_ff.ccr[OAG_CCR_H];
            4'h9: cond_true = cur_ff.ccr[OAG_CCR_H];
            4'ha: cond_true = !cur_ff.ccr[OAG_CCR_N];
            4'hb: cond_true = cur_ff.ccr[OAG_CCR_N];
            4'hc: cond_true = !cur_ff.ccr[OAG_CCR_I];
            4'hd: cond_true = cur_ff.ccr[OAG_CCR_I];
            4'he: cond_true = !cur_ff.irq_sync[1];
            4'hf: cond_true = cur_ff.irq_sync[1];
            default: cond_true = 1'b0;
        endcase
    end

    // Next sequential instruction and branch target
    assign tested_bit = mem_rdata_i[cur_ff.op[3:1]];
    assign rel_byte = (cls == OAG_CLS_BTB) ? cur_ff.b2 : cur_ff.b1;
    assign pc_seq = cur_ff.pc + {14'h0000, len}; // [RULE8]
    assign pc_target = pc_seq + {{8{rel_byte[7]}}, rel_byte}; // [RULE7]

    oag_alu u_alu (
        .op_i(cur_ff.op[3:0]),
        .acc_i(cur_ff.acc),
        .idx_i(cur_ff.idx),
        .opnd_i(mem_rdata_i),
        .carry_i(cur_ff.ccr[OAG_CCR_C]),
        .res_o(alu_res),
        .wr_acc_o(alu_wr_acc),
        .wr_idx_o(alu_wr_idx),
        .upd_c_o(alu_upd_c),
        .upd_h_o(alu_upd_h),
        .c_o(alu_c),
        .h_o(alu_h)
    );

    // Sequencer: fetch operands, issue the data access, complete
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.irq_sync = {cur_ff.irq_sync[0], irq_pin_i};
        nxt_cur.rd = 1'b0;
        nxt_cur.wr = 1'b0;
        nxt_cur.done = 1'b0;
        nxt_cur.illegal = 1'b0;
        nxt_cur.cyc = cur_ff.cyc + 3'h1;
        if (cur_ff.cyc == OAG_CYC_FIRST) begin
            nxt_cur.op = mem_rdata_i;
        end
        if (cur_ff.cyc == 3'h2) begin
            nxt_cur.b1 = mem_rdata_i; // First byte after opcode
        end
        if (cur_ff.cyc == 3'h3) begin
            nxt_cur.b2 = mem_rdata_i; // Second byte after opcode
        end
        // Program bytes after the opcode
        if (cur_ff.cyc == OAG_CYC_FIRST && len != OAG_LEN_1) begin
            nxt_cur.addr = cur_ff.pc + 16'h0001;
            nxt_cur.rd = 1'b1;
        end
        if (cur_ff.cyc == 3'h2 && len == OAG_LEN_3) begin
            nxt_cur.addr = cur_ff.pc + 16'h0002;
            nxt_cur.rd = 1'b1;
        end
        // Data access at the effective address; X itself is left alone [RULE6]
        if (cur_ff.cyc == ea_cyc) begin
            nxt_cur.addr = ea;
            if (is_store) begin
                nxt_cur.wr = 1'b1;
                nxt_cur.wdata = (op_cur[3:0] == OAG_STORE_ACC) ? cur_ff.acc : cur_ff.idx;
            end else begin
                nxt_cur.rd = 1'b1;
            end
        end
        // Completion: execute and fetch the next opcode
        if (cur_ff.cyc == fin_cyc) begin
            nxt_cur.cyc = OAG_CYC_FIRST;
            nxt_cur.done = 1'b1;
            nxt_cur.rd = 1'b1;
            nxt_cur.pc = pc_seq;
            case (cls)
                OAG_CLS_ALU: begin
                    if (alu_wr_acc) begin
                        nxt_cur.acc = alu_res;
                    end
                    if (alu_wr_idx) begin
                        nxt_cur.idx = alu_res;
                    end
                    nxt_cur.ccr[OAG_CCR_N] = alu_res[7];
                    nxt_cur.ccr[OAG_CCR_Z] = (alu_res == 8'h00);
                    if (alu_upd_c) begin
                        nxt_cur.ccr[OAG_CCR_C] = alu_c;
                    end
                    if (alu_upd_h) begin
                        nxt_cur.ccr[OAG_CCR_H] = alu_h;
                    end
                end
                OAG_CLS_REL: begin
                    if (cond_true) begin
                        nxt_cur.pc = pc_target; // [RULE7] [RULE10]
                    end
                end
                OAG_CLS_BTB: begin
                    nxt_cur.ccr[OAG_CCR_C] = tested_bit;
                    if (tested_bit ^ cur_ff.op[0]) begin
                        nxt_cur.pc = pc_target; // [RULE11]
                    end
                end
                default: begin
                    nxt_cur.illegal = 1'b1; // Unsupported opcode runs as a one-byte no-op
                end
            endcase
            nxt_cur.addr = nxt_cur.pc;
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_ff <= OAG_STATE_RESET;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs straight from the state register
    assign mem_addr_o = cur_ff.addr;
    assign mem_rd_o = cur_ff.rd;
    assign mem_wr_o = cur_ff.wr;
    assign mem_wdata_o = cur_ff.wdata;
    assign pc_o = cur_ff.pc;
    assign acc_o = cur_ff.acc;
    assign idx_o = cur_ff.idx;
    assign ccr_o = cur_ff.ccr;
    assign insn_done_o = cur_ff.done;
    assign illegal_op_o = cur_ff.illegal;

endmodule // oag_core
`default_nettype wire

// ==== shared/oag_pkg.sv ====
// Constants and types shared by the operand address generator and its ALU
package oag_pkg;

    // Program counter value taken at reset (plain default, no vector fetch)
    localparam logic [15:0] OAG_RESET_PC = 16'h0100;

    // Opcode groups selected by the upper nibble
    localparam logic [3:0] OAG_HI_BTB = 4'h0;
    localparam logic [3:0] OAG_HI_REL = 4'h2;
    localparam logic [3:0] OAG_HI_IMM = 4'ha;
    localparam logic [7:0] OAG_OP_BRANCH_IF_ZERO = 8'h27;

    // Cycles per instruction, counted from the opcode cycle as cycle 1
    localparam logic [2:0] OAG_CYC_IMM = 3'h2;
    localparam logic [2:0] OAG_CYC_DIR = 3'h3;
    localparam logic [2:0] OAG_CYC_EXT = 3'h4;
    localparam logic [2:0] OAG_CYC_IX = 3'h3;
    localparam logic [2:0] OAG_CYC_IX1 = 3'h4;
    localparam logic [2:0] OAG_CYC_IX2 = 3'h5;
    localparam logic [2:0] OAG_CYC_REL = 3'h3;
    localparam logic [2:0] OAG_CYC_BTB = 3'h5;
    localparam logic [2:0] OAG_CYC_NOP = 3'h2;
    localparam logic [2:0] OAG_CYC_STORE_EXTRA = 3'h1;
    localparam logic [2:0] OAG_CYC_FIRST = 3'h1;

    // Instruction lengths in bytes
    localparam logic [1:0] OAG_LEN_1 = 2'h1;
    localparam logic [1:0] OAG_LEN_2 = 2'h2;
    localparam logic [1:0] OAG_LEN_3 = 2'h3;

    // Condition code bit positions and reset value
    localparam int OAG_CCR_H = 4;
    localparam int OAG_CCR_I = 3;
    localparam int OAG_CCR_N = 2;
    localparam int OAG_CCR_Z = 1;
    localparam int OAG_CCR_C = 0;
    localparam logic [4:0] OAG_CCR_RESET = 5'h08;

    // Operation chosen by the lower nibble of a register/memory opcode
    typedef enum logic [3:0] {
        OAG_SUB = 4'h0,
        OAG_COMPARE_ACCUMULATOR_OP = 4'h1,
        OAG_SUBTRACT_WITH_BORROW_OP = 4'h2,
        OAG_COMPARE_INDEX_OP = 4'h3,
        OAG_AND = 4'h4,
        OAG_BIT_TEST = 4'h5,
        OAG_LOAD_ACCUMULATOR_OP = 4'h6,
        OAG_STORE_ACC = 4'h7,
        OAG_EXCLUSIVE_OR_OP = 4'h8,
        OAG_ADD_WITH_CARRY = 4'h9,
        OAG_OR = 4'ha,
        OAG_ADD = 4'hb,
        OAG_JUMP = 4'hc,
        OAG_JUMP_SUB = 4'hd,
        OAG_LOAD_INDEX = 4'he,
        OAG_STORE_INDEX = 4'hf
    } oag_alu_op_e;

    // Addressing mode, upper nibble minus A
    typedef enum logic [2:0] {
        OAG_MODE_IMM = 3'h0,
        OAG_MODE_DIR = 3'h1,
        OAG_MODE_EXT = 3'h2,
        OAG_MODE_IX2 = 3'h3,
        OAG_MODE_IX1 = 3'h4,
        OAG_MODE_IX = 3'h5
    } oag_mode_e;

    // Instruction class
    typedef enum logic [1:0] {
        OAG_CLS_NOP = 2'h0,
        OAG_CLS_ALU = 2'h1,
        OAG_CLS_REL = 2'h2,
        OAG_CLS_BTB = 2'h3
    } oag_class_e;

endpackage

// ==== verification/oag_core_assertions.sv ====
// Concurrent checks on the ports of the operand address generator core
`timescale 1ns/100ps
`default_nettype none
module oag_core_assertions (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic irq_pin_i,
    input wire logic [15:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [15:0] pc_o,
    input wire logic [7:0] acc_o,
    input wire logic [7:0] idx_o,
    input wire logic [4:0] ccr_o,
    input wire logic insn_done_o,
    input wire logic illegal_op_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    // Opcode cycle of a memory-operand group member, jumps left out
    function automatic logic fam(input logic d, input logic [7:0] r, input logic [3:0] hi);
        return d && r[7:4] == hi && r[3:1] != 3'h6;
    endfunction

    a_store_then_idle: assert property (mem_wr_o |=> !mem_wr_o && !mem_rd_o)
        else $error("store cycle not followed by an idle cycle");
    a_done_at_fetch: assert property (insn_done_o |-> mem_rd_o && mem_addr_o == pc_o)
        else $error("completion pulse not in an opcode fetch at pc");
    a_illegal_with_done: assert property (illegal_op_o |-> insn_done_o)
        else $error("unsupported opcode pulse outside completion");
    a_direct_addr: assert property (fam(insn_done_o, mem_rdata_i, 4'hb) |->
        ##2 mem_addr_o == {8'h00, $past(mem_rdata_i)})
        else $error("direct address wrong");
    a_noofs_addr: assert property (fam(insn_done_o, mem_rdata_i, 4'hf) |->
        ##2 mem_addr_o == {8'h00, idx_o})
        else $error("no-offset indexed address wrong");
    a_short_ofs_addr: assert property (fam(insn_done_o, mem_rdata_i, 4'he) |->
        ##3 mem_addr_o == {8'h00, $past(mem_rdata_i, 2)} + {8'h00, idx_o})
        else $error("short-offset indexed address wrong");
    a_long_ofs_addr: assert property (fam(insn_done_o, mem_rdata_i, 4'hd) |->
        ##4 mem_addr_o == {$past(mem_rdata_i, 3), $past(mem_rdata_i, 2)} + {8'h00, idx_o})
        else $error("long-offset indexed address wrong");
    a_index_kept: assert property ((fam(insn_done_o, mem_rdata_i, 4'hd)
        || fam(insn_done_o, mem_rdata_i, 4'he)) && mem_rdata_i[3:0] != 4'he
        |=> $stable(idx_o) [*4])
        else $error("index register changed by offset addressing");
    a_zero_branch_taken: assert property (insn_done_o && mem_rdata_i == 8'h27 && ccr_o[1] |->
        ##3 insn_done_o && pc_o == $past(pc_o, 3) + 16'h0002 + 16'($signed($past(mem_rdata_i, 2))))
        else $error("taken zero branch target wrong");
    a_zero_branch_fall: assert property (insn_done_o && mem_rdata_i == 8'h27 && !ccr_o[1] |->
        ##3 insn_done_o && pc_o == $past(pc_o, 3) + 16'h0002)
        else $error("untaken zero branch did not fall through");

    // Main scenarios reached
    c_short_ofs: cover property (fam(insn_done_o, mem_rdata_i, 4'he));
    c_store: cover property (mem_wr_o);
    c_illegal: cover property (illegal_op_o);
endmodule // oag_core_assertions

bind oag_core oag_core_assertions oag_core_assertions_inst (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mem_rdata_i(mem_rdata_i), .irq_pin_i(irq_pin_i),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o), .pc_o(pc_o), .acc_o(acc_o), .idx_o(idx_o), .ccr_o(ccr_o),
    .insn_done_o(insn_done_o), .illegal_op_o(illegal_op_o)
);
`default_nettype wire

// ==== verification/oag_mem_model.sv ====
// Program and data memory with asynchronous read and clocked write
`timescale 1ns/100ps
`default_nettype none
module oag_mem_model (
    input wire logic clk_i,
    input wire logic [15:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;

    // Unselected cycles show the inverse of the last byte, never a stale copy
    assign rdata_o = rd_i ? mem[addr_i] : ~last_q;

    // Write on the edge that ends a store cycle; remember the last byte shown
    always @(posedge clk_i) begin
        if (wr_i) mem[addr_i] <= wdata_i;
        if (rd_i) last_q <= mem[addr_i];
    end
endmodule // oag_mem_model
`default_nettype wire

// ==== verification/tb_oag_core.sv ====
// Self-checking bench for the operand address generator core
`timescale 1ns/100ps
`default_nettype none
module tb_oag_core;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic irq_pin_i = 1'b0;
    wire logic [7:0] mem_rdata_i;
    wire logic [15:0] mem_addr_o;
    wire logic mem_rd_o;
    wire logic mem_wr_o;
    wire logic [7:0] mem_wdata_o;
    wire logic [15:0] pc_o;
    wire logic [7:0] acc_o;
    wire logic [7:0] idx_o;
    wire logic [4:0] ccr_o;
    wire logic insn_done_o;
    wire logic illegal_op_o;
    int n_mismatch = 0;
    int cmp_count = 0;

    // 50 MHz clock
    always #10 clk_sys_i = ~clk_sys_i;

    oag_core oag_core_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mem_rdata_i(mem_rdata_i),
        .irq_pin_i(irq_pin_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
        .mem_wdata_o(mem_wdata_o), .pc_o(pc_o), .acc_o(acc_o), .idx_o(idx_o), .ccr_o(ccr_o),
        .insn_done_o(insn_done_o), .illegal_op_o(illegal_op_o));
    oag_mem_model oag_mem_model_inst (.clk_i(clk_sys_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
        .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

    // Compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Background contents of data memory
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    // Place a program at the reset address
    task automatic prog(input logic [7:0] b[$]);
        foreach (b[i]) oag_mem_model_inst.mem[16'h0100 + i] = b[i];
    endtask

    // Reset, run n instructions, then judge acc, Z/C, last cycle count and pc
    task automatic step(input int n, input logic [7:0] ea, input logic [1:0] ezc,
                        input logic [2:0] ecyc, input logic [15:0] epc);
        int k;
        int c;
        int t;
        logic [2:0] lc;
        k = 0;
        c = 0;
        lc = 3'h0;
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        for (t = 0; t < 100 && k < n; t++) begin
            @(posedge clk_sys_i);
            #1;
            c++;
            if (insn_done_o === 1'b1) begin
                k++;
                lc = c[2:0];
                c = 0;
            end
        end
        chk("done count", 16'(k), 16'(n));
        chk("acc", {8'h00, acc_o}, {8'h00, ea});
        chk("zc", {14'h0, ccr_o[1:0]}, {14'h0, ezc});
        chk("cycles", {13'h0, lc}, {13'h0, ecyc});
        chk("pc", pc_o, epc);
    endtask

    // Indexed modes with X at its top value
    task automatic t_indexed;
        prog('{8'hae, 8'hff, 8'hf6, 8'he6, 8'hff, 8'hd6, 8'h07, 8'h00});
        step(2, pat(16'h00ff), 2'b00, 3'h3, 16'h0103);
        step(3, pat(16'h01fe), 2'b00, 3'h4, 16'h0105);
        step(4, pat(16'h07ff), 2'b00, 3'h5, 16'h0108);
        chk("idx", {8'h00, idx_o}, 16'h00ff);
        $display("indexed test done");
    endtask

    // Direct store, direct read back, extended read
    task automatic t_direct;
        prog('{8'ha6, 8'h81, 8'hb7, 8'h50, 8'ha6, 8'h00, 8'hb6, 8'h50, 8'hc6, 8'h02, 8'h34});
        step(2, 8'h81, 2'b00, 3'h4, 16'h0104);
        chk("stored", {8'h00, oag_mem_model_inst.mem[16'h0050]}, 16'h0081);
        step(4, 8'h81, 2'b00, 3'h3, 16'h0108);
        step(5, pat(16'h0234), 2'b00, 3'h4, 16'h010b);
        $display("direct test done");
    endtask

    // Arithmetic with borrow and carry, compares, exclusive-or, logical compare
    task automatic t_alu;
        prog('{8'ha6, 8'h10, 8'ha0, 8'h20, 8'ha2, 8'h01, 8'ha1, 8'hff,
               8'ha9, 8'h01, 8'ha8, 8'h0f, 8'ha5, 8'h00, 8'ha3, 8'h00});
        step(2, 8'hf0, 2'b01, 3'h2, 16'h0104);
        step(3, 8'hee, 2'b00, 3'h2, 16'h0106);
        step(4, 8'hee, 2'b01, 3'h2, 16'h0108);
        step(5, 8'hf0, 2'b00, 3'h2, 16'h010a);
        step(6, 8'hff, 2'b00, 3'h2, 16'h010c);
        step(7, 8'hff, 2'b10, 3'h2, 16'h010e);
        step(8, 8'hff, 2'b10, 3'h2, 16'h0110);
        $display("alu test done");
    endtask

    // Zero branch not taken, then taken backwards by the full byte reach
    task automatic t_branch;
        prog('{8'ha6, 8'h01, 8'h27, 8'h05, 8'ha6, 8'h00, 8'h27, 8'h80});
        step(2, 8'h01, 2'b00, 3'h3, 16'h0104);
        step(4, 8'h00, 2'b10, 3'h3, 16'h0088);
        $display("branch test done");
    endtask

    // Bit test branches on a direct-page byte
    task automatic t_bit_branch;
        prog('{8'h00, 8'h40, 8'h05, 8'h05, 8'h40, 8'h02, 8'h04, 8'h40, 8'h10});
        step(1, 8'h00, 2'b00, 3'h5, 16'h0103);
        step(2, 8'h00, 2'b01, 3'h5, 16'h0106);
        step(3, 8'h00, 2'b01, 3'h5, 16'h0119);
        $display("bit branch test done");
    endtask

    // Both compare families in all six modes, then an unsupported opcode
    task automatic t_decode;
        logic [2:0] cyc [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h4, 3'h3};
        logic [15:0] len [6] = '{16'h2, 16'h2, 16'h3, 16'h3, 16'h2, 16'h1};
        for (int m = 0; m < 6; m++) begin
            for (int k = 0; k < 2; k++) begin
                prog('{{4'ha + 4'(m), k == 1 ? 4'h3 : 4'h1}, 8'h00, 8'h00});
                step(1, 8'h00, m == 0 ? 2'b10 : 2'b01, cyc[m], 16'h0100 + len[m]);
            end
        end
        prog('{8'h9d});
        step(1, 8'h00, 2'b00, 3'h2, 16'h0101);
        chk("illegal", {15'h0, illegal_op_o}, 16'h0001);
        $display("decode test done");
    endtask

    // Main sequence
    initial begin
        for (int a = 0; a < 65536; a++) oag_mem_model_inst.mem[a] = pat(16'(a));
        repeat (6) @(posedge clk_sys_i);
        t_indexed();
        t_direct();
        t_alu();
        t_branch();
        t_bit_branch();
        t_decode();
        conclude();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        conclude();
    end
endmodule // tb_oag_core
`default_nettype wire
